// File: rtl/mcd_pkg.sv
package mcd_pkg;

  // ----------------------------------------------------------------------
  // widths and word fields
  // ----------------------------------------------------------------------
  localparam int WORD_W = 14;   // instruction word
  localparam int DATA_W = 8;    // data path
  localparam int ADDR_W = 7;    // file address
  localparam int TGT_W = 11;    // transfer target literal

  // top two bits select the format
  localparam logic [1:0] FMT_BYTE = 2'h0;
  localparam logic [1:0] FMT_BIT = 2'h1;
  localparam logic [1:0] FMT_CTRL = 2'h2;
  localparam logic [1:0] FMT_LIT = 2'h3;

  // byte-oriented opcodes, word bits 11:8
  localparam logic [3:0] OP_MISC = 4'h0;   // store_accum or fixed words
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [3:0] OP_DECSZ = 4'hb;
  localparam logic [3:0] OP_RRC = 4'hc;
  localparam logic [3:0] OP_RLC = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INCSZ = 4'hf;

  // bit-oriented opcodes, word bits 11:10
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKC = 2'h2;
  localparam logic [1:0] BOP_SKS = 2'h3;

  // fixed words
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_INT_RETURN = 14'h0009;
  localparam logic [13:0] W_WDT_CLEAR = 14'h0064;
  localparam logic [13:0] W_STANDBY = 14'h0063;
  localparam logic [13:0] W_NOP_MASK = 14'h3f9f;   // bits 6:5 free

  // file address of the timer-0 count register
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;

  // values after reset
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic POWERDOWN_RESET = 1'b1;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_COM, ALU_PASS,
    ALU_INC, ALU_DEC, ALU_RLC, ALU_RRC, ALU_SWAP, ALU_CLR, ALU_PASSW,
    ALU_BCLR, ALU_BSET
  } mcd_alu_op_t;

  typedef enum logic {PH_EXEC, PH_BUBBLE} mcd_phase_t;

  typedef struct packed {
    logic timeoutFlag;
    logic powerdownFlag;
    logic zero;
    logic halfCarryFlag;
    logic carry;
  } mcd_status_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } mcd_file_wr_t;

  typedef struct packed {
    logic load;
    logic [10:0] target;
    logic push;
    logic pop;
  } mcd_pc_ctl_t;

  typedef struct packed {
    mcd_phase_t phase;
    logic busy;
    logic [7:0] accum;
    mcd_status_t status;
    mcd_file_wr_t fileWr;
    mcd_pc_ctl_t pcCtl;
    logic skipNext;
    logic prescClear;
    logic watchdogClear;
    logic standbyReq;
    logic intReturn;
  } mcd_core_state_t;

endpackage

// File: rtl/mcd_alu.sv
`timescale 1ns/1ps
module mcd_alu
  import mcd_pkg::*;
(
  input wire mcd_alu_op_t op,
  input wire logic [7:0] opA,
  input wire logic [7:0] accum,
  input wire logic [2:0] bitSel,
  input wire logic carryIn,
  output logic [7:0] result,
  output logic carryOut,
  output logic halfCarryOut
);

  // ----------------------------------------------------------------------
  // arithmetic and logic, purely combinational
  // ----------------------------------------------------------------------
  logic [8:0] sum;   // full sum with carry
  logic [4:0] nib;   // low nibble sum for digit carry
  logic [7:0] bitMask;

  // one operation per cycle, carry means no borrow on subtract
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    bitMask = 8'h01 << bitSel;
    result = opA;
    carryOut = carryIn;
    halfCarryOut = 1'b0;
    case (op)
      ALU_ADD: begin
        sum = {1'b0, opA} + {1'b0, accum};
        nib = {1'b0, opA[3:0]} + {1'b0, accum[3:0]};
        result = sum[7:0];
        carryOut = sum[8];
        halfCarryOut = nib[4];
      end
      ALU_SUB: begin
        sum = {1'b0, opA} + {1'b0, ~accum} + 9'h001;
        nib = {1'b0, opA[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;
        result = sum[7:0];
        carryOut = sum[8];
        halfCarryOut = nib[4];
      end
      ALU_AND: result = opA & accum;
      ALU_OR: result = opA | accum;
      ALU_XOR: result = opA ^ accum;
      ALU_COM: result = ~opA;
      ALU_INC: result = opA + 8'h01;
      ALU_DEC: result = opA - 8'h01;
      // rotates go through the carry
      ALU_RLC: begin
        result = {opA[6:0], carryIn};
        carryOut = opA[7];
      end
      ALU_RRC: begin
        result = {carryIn, opA[7:1]};
        carryOut = opA[0];
      end
      ALU_SWAP: result = {opA[3:0], opA[7:4]};
      ALU_CLR: result = 8'h00;
      ALU_PASSW: result = accum;
      ALU_BCLR: result = opA & ~bitMask;
      ALU_BSET: result = opA | bitMask;
      default: result = opA;   // plain move
    endcase
  end

endmodule

// File: rtl/mcd_instr_decode.sv
`timescale 1ns/1ps
module mcd_instr_decode
  import mcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [13:0] instrWord,
  input wire logic [7:0] fileRdData,
  input wire logic [7:0] pinRdData,
  input wire logic portAddrHit,
  input wire logic prescToTimer,
  output logic busy,
  output logic [7:0] accum,
  output mcd_status_t status,
  output mcd_file_wr_t fileWr,
  output mcd_pc_ctl_t pcCtl,
  output logic skipNext,
  output logic prescClear,
  output logic watchdogClear,
  output logic standbyReq,
  output logic intReturn
);

  // ----------------------------------------------------------------------
  // state and word fields
  // ----------------------------------------------------------------------
  mcd_core_state_t state_reg;   // whole core state
  mcd_core_state_t state_next;

  logic [1:0] fmt;   // format select
  logic [3:0] byteOp;   // byte opcode
  logic destFile;   // destination bit
  logic [6:0] fileAddr;
  logic [1:0] bitOp;
  logic [2:0] bitSel;
  logic [7:0] literal;
  logic accept;   // word taken this cycle

  assign fmt = instrWord[13:12];
  assign byteOp = instrWord[11:8];
  assign destFile = instrWord[7];
  assign fileAddr = instrWord[6:0];
  assign bitOp = instrWord[11:10];
  assign bitSel = instrWord[9:7];
  assign literal = instrWord[7:0];
  assign accept = instrValid && (state_reg.phase == PH_EXEC);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  mcd_alu_op_t aluOp;
  logic useLit;   // literal replaces the file operand
  logic setC, setDc, setZ;   // flag update mask
  logic toFile, toAccum;   // result destination
  logic skipOnZero, skipOnClr, skipOnSet;
  logic pcLd, pcPush, pcPop, isIntRet, isWdt, isStandby;
  logic [7:0] opA;   // selected operand
  logic [7:0] aluRes;
  logic aluC, aluDc;
  logic skipTaken;

  // pins stand in for the latch on port reads
  assign opA = useLit ? literal :
               (portAddrHit ? pinRdData : fileRdData);

  always_comb begin
    aluOp = ALU_PASS;
    useLit = 1'b0;
    {setC, setDc, setZ} = 3'b000;
    {toFile, toAccum} = 2'b00;
    {skipOnZero, skipOnClr, skipOnSet} = 3'b000;
    {pcLd, pcPush, pcPop} = 3'b000;
    {isIntRet, isWdt, isStandby} = 3'b000;
    case (fmt)
      FMT_BYTE: begin
        toFile = destFile;
        toAccum = !destFile;
        case (byteOp)
          OP_MISC: begin
            toAccum = 1'b0;
            if (destFile) begin
              aluOp = ALU_PASSW;
            end else if (instrWord == W_RETURN) begin
              {pcLd, pcPop} = 2'b11;
            end else if (instrWord == W_INT_RETURN) begin
              {pcLd, pcPop, isIntRet} = 3'b111;
            end else if (instrWord == W_WDT_CLEAR) begin
              isWdt = 1'b1;
            end else if (instrWord == W_STANDBY) begin
              isStandby = 1'b1;
            end
            // nop and spare words do nothing
          end
          OP_CLR: aluOp = ALU_CLR;
          OP_AND: aluOp = ALU_AND;
          OP_OR: aluOp = ALU_OR;
          OP_XOR: aluOp = ALU_XOR;
          OP_COM: aluOp = ALU_COM;
          OP_MOV: aluOp = ALU_PASS;
          OP_INC: aluOp = ALU_INC;
          OP_DEC: aluOp = ALU_DEC;
          OP_DECSZ: aluOp = ALU_DEC;
          OP_INCSZ: aluOp = ALU_INC;
          OP_RLC: aluOp = ALU_RLC;
          OP_RRC: aluOp = ALU_RRC;
          OP_SWAP: aluOp = ALU_SWAP;
          OP_ADD: aluOp = ALU_ADD;
          default: aluOp = ALU_SUB;
        endcase
        // flag masks and skip test by opcode group
        setZ = byteOp inside {OP_CLR, OP_AND, OP_OR, OP_XOR, OP_COM,
                              OP_MOV, OP_INC, OP_DEC, OP_ADD, OP_SUB};
        setC = byteOp inside {OP_RLC, OP_RRC, OP_ADD, OP_SUB};
        setDc = byteOp inside {OP_ADD, OP_SUB};
        skipOnZero = byteOp inside {OP_DECSZ, OP_INCSZ};
      end
      FMT_BIT: begin
        toFile = !bitOp[1];
        case (bitOp)
          BOP_CLR: aluOp = ALU_BCLR;
          BOP_SET: aluOp = ALU_BSET;
          BOP_SKC: skipOnClr = 1'b1;
          default: skipOnSet = 1'b1;
        endcase
      end
      FMT_CTRL: begin
        pcLd = 1'b1;
        pcPush = !instrWord[11];
      end
      default: begin
        useLit = 1'b1;
        toAccum = 1'b1;
        // bits 11:8 pick the literal operation
        case (instrWord[11:8])
          4'h0, 4'h1, 4'h2, 4'h3: aluOp = ALU_PASS;
          4'h4, 4'h5, 4'h6, 4'h7: {pcLd, pcPop} = 2'b11;
          4'h8: aluOp = ALU_OR;
          4'h9: aluOp = ALU_AND;
          4'ha: aluOp = ALU_XOR;
          4'hc, 4'hd: aluOp = ALU_SUB;
          4'he, 4'hf: aluOp = ALU_ADD;
          default: toAccum = 1'b0;   // spare pattern acts as nop
        endcase
        setZ = instrWord[11] && (instrWord[11:8] != 4'hb);
        setC = (instrWord[11:10] == 2'h3);
        setDc = (instrWord[11:10] == 2'h3);
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // arithmetic unit
  // ----------------------------------------------------------------------
  mcd_alu u_alu (
    .op(aluOp),
    .opA(opA),
    .accum(state_reg.accum),
    .bitSel(bitSel),
    .carryIn(state_reg.status.carry),
    .result(aluRes),
    .carryOut(aluC),
    .halfCarryOut(aluDc)
  );

  assign skipTaken = (skipOnZero && (aluRes == 8'h00)) ||
                     (skipOnClr && !opA[bitSel]) ||
                     (skipOnSet && opA[bitSel]);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.busy = 1'b0;
    state_next.fileWr.we = 1'b0;
    state_next.pcCtl.load = 1'b0;
    state_next.pcCtl.push = 1'b0;
    state_next.pcCtl.pop = 1'b0;
    state_next.skipNext = 1'b0;
    state_next.prescClear = 1'b0;
    state_next.watchdogClear = 1'b0;
    state_next.standbyReq = 1'b0;
    state_next.intReturn = 1'b0;
    case (state_reg.phase)
      PH_BUBBLE: state_next.phase = PH_EXEC;   // second cycle is a nop
      default: begin
        if (accept) begin
          if (toAccum) state_next.accum = aluRes;
          if (toFile) begin
            state_next.fileWr = {1'b1, fileAddr, aluRes};
            state_next.prescClear = prescToTimer &&
                                    (fileAddr == TIMER_ZERO_ADDR);
          end
          // unmasked flags keep their value
          if (setC) state_next.status.carry = aluC;
          if (setDc) state_next.status.halfCarryFlag = aluDc;
          if (setZ) state_next.status.zero = (aluRes == 8'h00);
          // watchdog clear and standby both set timeout
          if (isWdt || isStandby) begin
            state_next.status.timeoutFlag = 1'b1;
            state_next.status.powerdownFlag = isWdt;
          end
          state_next.watchdogClear = isWdt;
          state_next.standbyReq = isStandby;
          state_next.pcCtl = {pcLd, instrWord[10:0], pcPush, pcPop};
          state_next.intReturn = isIntRet;
          state_next.skipNext = skipTaken;
          if (pcLd || skipTaken) begin
            state_next.phase = PH_BUBBLE;
            state_next.busy = 1'b1;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= '0;   // phase starts in exec
      state_reg.accum <= ACCUM_RESET;
      state_reg.status.timeoutFlag <= TIMEOUT_RESET;
      state_reg.status.powerdownFlag <= POWERDOWN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign busy = state_reg.busy;
  assign accum = state_reg.accum;
  assign status = state_reg.status;
  assign fileWr = state_reg.fileWr;
  assign pcCtl = state_reg.pcCtl;
  assign skipNext = state_reg.skipNext;
  assign prescClear = state_reg.prescClear;
  assign watchdogClear = state_reg.watchdogClear;
  assign standbyReq = state_reg.standbyReq;
  assign intReturn = state_reg.intReturn;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence seqBubble;
    busy ##1 !busy;
  endsequence
  sequence seqJump;
    pcCtl.load && pcCtl.target == $past(instrWord[10:0]);
  endsequence

  AST_PC_BUBBLE: assert property (pcCtl.load |-> seqBubble)
    else $error("pc change without a single bubble");
  AST_SKIP_BUBBLE: assert property (skipNext |-> seqBubble)
    else $error("taken skip without a single bubble");
  AST_CTRL_XFER: assert property (accept && fmt == FMT_CTRL |=>
    seqJump ##0 (pcCtl.push == !$past(instrWord[11])) ##1 !busy)
    else $error("transfer target or call push wrong");
  AST_KEEP_FLAGS: assert property (accept && fmt == FMT_BYTE &&
    byteOp == OP_SWAP |=> $stable(status))
    else $error("nibble exchange changed flags");
  AST_ZERO_FLAG: assert property (accept && setZ |=>
    status.zero == ($past(aluRes) == 8'h00))
    else $error("zero flag disagrees with result");
  AST_DEST_ACCUM: assert property (accept && fmt == FMT_BYTE &&
    !destFile && byteOp != OP_MISC |=>
    accum == $past(aluRes) && !fileWr.we)
    else $error("accumulator destination not honoured");
  AST_PRESC: assert property (prescClear |-> fileWr.we &&
    fileWr.addr == TIMER_ZERO_ADDR && $past(prescToTimer))
    else $error("prescaler clear without timer write");
  AST_STANDBY: assert property (accept && instrWord == W_STANDBY |=>
    status.timeoutFlag && !status.powerdownFlag && standbyReq && !busy)
    else $error("standby flags or timing wrong");
  AST_PORT_PINS: assert property (accept && portAddrHit && fmt == FMT_BIT &&
    bitOp == BOP_SET |=> fileWr.data ==
    ($past(pinRdData) | (8'h01 << $past(bitSel))))
    else $error("port operand not taken from pins");

endmodule

// File: verif/mcd_file_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// data file registers and port pins
// ----------------------------------------------------------------------
module mcd_file_model
  import mcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [13:0] instrWord,
  input wire mcd_file_wr_t fileWr,
  input wire logic [7:0] extPullLow,
  output logic [7:0] fileRdData,
  output logic [7:0] pinRdData,
  output logic portAddrHit
);
  logic [7:0] fileMem [128]; // file contents
  logic [6:0] rdAddr; // operand address field
  assign rdAddr = instrWord[6:0];
  // ports sit at file addresses 05 to 09
  assign portAddrHit = (rdAddr >= 7'h05) && (rdAddr <= 7'h09);
  assign fileRdData = fileMem[rdAddr]; // latch content
  // pins follow the latch unless pulled low from outside
  always_comb begin
    if (portAddrHit) begin
      pinRdData = fileMem[rdAddr] & ~extPullLow;
    end else begin
      pinRdData = ~fileMem[rdAddr]; // no pins here
    end
  end
  // clear file at start
  initial begin
    foreach (fileMem[i]) fileMem[i] = 8'h00;
  end
  // write taken at the edge
  always @(posedge clk_sys) begin
    if (fileWr.we) begin
      fileMem[fileWr.addr] <= fileWr.data;
    end
  end
endmodule

// File: verif/mcd_instr_decode_tb.sv
`timescale 1ns/1ps
module mcd_instr_decode_tb;
  import mcd_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  logic [13:0] instrWord = 14'h0000;
  logic prescToTimer = 1'b0;
  logic [7:0] extPullLow = 8'h00;
  logic [7:0] fileRdData, pinRdData, accum;
  logic portAddrHit, busy, skipNext, prescClear;
  logic watchdogClear, standbyReq, intReturn;
  mcd_status_t status;
  mcd_file_wr_t fileWr;
  mcd_pc_ctl_t pcCtl;
  int num_errors = 0;
  int compares = 0;
  // word, accumulator, zero; accumulator preset to 0f, file 23 holds f0
  localparam logic [22:0] LOGIC_TBL [17] = '{
    {14'h0523, 8'h00, 1'b1}, {14'h0423, 8'hff, 1'b0},
    {14'h0100, 8'h00, 1'b1}, {14'h0623, 8'hff, 1'b0},
    {14'h39f0, 8'h00, 1'b1}, {14'h3800, 8'h0f, 1'b0},
    {14'h3a0f, 8'h00, 1'b1}, {14'h0923, 8'h0f, 1'b0},
    {14'h3900, 8'h00, 1'b1}, {14'h0823, 8'hf0, 1'b0},
    {14'h0100, 8'h00, 1'b1}, {14'h0a23, 8'hf1, 1'b0},
    {14'h3a0f, 8'h00, 1'b1}, {14'h0323, 8'hef, 1'b0},
    {14'h3a0f, 8'h00, 1'b1}, {14'h3233, 8'h33, 1'b1},
    {14'h0e23, 8'h0f, 1'b1}};

  mcd_instr_decode i_dut (.clk_sys(clk_sys), .rst(rst),
    .instrValid(instrValid), .instrWord(instrWord),
    .fileRdData(fileRdData), .pinRdData(pinRdData),
    .portAddrHit(portAddrHit), .prescToTimer(prescToTimer),
    .busy(busy), .accum(accum), .status(status), .fileWr(fileWr),
    .pcCtl(pcCtl), .skipNext(skipNext), .prescClear(prescClear),
    .watchdogClear(watchdogClear), .standbyReq(standbyReq),
    .intReturn(intReturn));

  mcd_file_model i_file (.clk_sys(clk_sys), .instrWord(instrWord),
    .fileWr(fileWr), .extPullLow(extPullLow), .fileRdData(fileRdData),
    .pinRdData(pinRdData), .portAddrHit(portAddrHit));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one word for one cycle; returns inside the answer cycle
  task automatic run(input logic [13:0] w);
    @(negedge clk_sys);
    instrValid = 1'b1;
    instrWord = w;
    @(negedge clk_sys);
    instrValid = 1'b0;
  endtask

  task automatic expect_core(input logic [7:0] a, input logic [4:0] s);
    check("accum", 16'(accum), 16'(a));
    check("status", 16'(status), 16'(s));
  endtask

  // address and data only looked at when a write is expected
  task automatic expect_wr(input logic we, input logic [6:0] ad,
                           input logic [7:0] d);
    check("fileWr.we", 16'(fileWr.we), 16'(we));
    if (we) check("fileWr", 16'(fileWr), {we, ad, d});
  endtask

  task automatic expect_skip(input logic s);
    check("skipNext", 16'(skipNext), 16'(s));
    check("busy", 16'(busy), 16'(s));
  endtask

  task automatic expect_pc(input logic [13:0] p, input logic ir);
    check("pcCtl", 16'(pcCtl), 16'(p));
    check("busy", 16'(busy), 16'h0001);
    check("intReturn", 16'(intReturn), 16'(ir));
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic sc_arith();
    expect_core(8'h00, 5'h18);
    run(14'h300f);
    run(14'h00a0);
    expect_wr(1'b1, 7'h20, 8'h0f);
    run(14'h3001);
    run(14'h07a0);
    expect_wr(1'b1, 7'h20, 8'h10);
    check("status", 16'(status), 16'h001a);
    run(14'h0220);
    expect_wr(1'b0, 7'h00, 8'h00);
    expect_core(8'h0f, 5'h19);
    run(14'h3ef1);
    expect_core(8'h00, 5'h1f);
    // subtract from literal: literal minus accumulator
    run(14'h3c05);
    expect_core(8'h05, 5'h1b);
    run(14'h3d07);
    expect_core(8'h02, 5'h1b);
  endtask

  // every single-flag byte and literal code with zero alternating, then a literal move and a swap that keep zero
  task automatic sc_logic();
    run(14'h30f0);
    run(14'h00a3);
    for (int i = 0; i < 17; i++) begin
      run(14'h300f);
      run(LOGIC_TBL[i][22:9]);
      expect_core(LOGIC_TBL[i][8:1], {2'b11, LOGIC_TBL[i][0], 2'b11});
      expect_wr(1'b0, 7'h00, 8'h00);
    end
    run(14'h01a3);
    expect_wr(1'b1, 7'h23, 8'h00);
    check("status", 16'(status), 16'h001f);
  endtask

  task automatic sc_rotate();
    run(14'h0da0);
    expect_wr(1'b1, 7'h20, 8'h21);
    check("status", 16'(status), 16'h001e);
    run(14'h0ca0);
    expect_wr(1'b1, 7'h20, 8'h10);
    check("status", 16'(status), 16'h001f);
  endtask

  task automatic sc_skip();
    run(14'h3001);
    run(14'h00a1);
    run(14'h3801);
    run(14'h0ba1);
    expect_wr(1'b1, 7'h21, 8'h00);
    expect_skip(1'b1);
    check("status", 16'(status), 16'h001b);
    run(14'h0ba1);
    expect_wr(1'b1, 7'h21, 8'hff);
    expect_skip(1'b0);
    run(14'h0fa1);
    expect_wr(1'b1, 7'h21, 8'h00);
    expect_skip(1'b1);
  endtask

  task automatic sc_bits();
    run(14'h15a1);
    expect_wr(1'b1, 7'h21, 8'h08);
    run(14'h19a1);
    expect_skip(1'b0);
    run(14'h1da1);
    expect_skip(1'b1);
    run(14'h11a1);
    expect_wr(1'b1, 7'h21, 8'h00);
    check("status", 16'(status), 16'h001b);
    run(14'h19a1);
    expect_skip(1'b1);
    run(14'h1da1);
    expect_skip(1'b0);
  endtask

  task automatic sc_ctrl();
    // call, then a word offered in the bubble must be dropped
    @(negedge clk_sys);
    instrValid = 1'b1;
    instrWord = 14'h2123;
    @(negedge clk_sys);
    instrWord = 14'h3099;
    expect_pc({1'b1, 11'h123, 2'b10}, 1'b0);
    @(negedge clk_sys);
    instrValid = 1'b0;
    check("accum", 16'(accum), 16'h0001);
    check("busy", 16'(busy), 16'h0000);
    run(14'h2923);
    expect_pc({1'b1, 11'h123, 2'b00}, 1'b0);
    run(14'h0008);
    expect_pc({1'b1, 11'h008, 2'b01}, 1'b0);
    run(14'h0009);
    expect_pc({1'b1, 11'h009, 2'b01}, 1'b1);
    run(14'h3477);
    expect_pc({1'b1, 11'h477, 2'b01}, 1'b0);
    check("accum", 16'(accum), 16'h0077);
  endtask

  task automatic sc_port();
    extPullLow = 8'h01;
    run(14'h30ff);
    run(14'h0085);
    expect_wr(1'b1, 7'h05, 8'hff);
    run(14'h1785);
    expect_wr(1'b1, 7'h05, 8'hfe);
    run(14'h0805);
    check("accum", 16'(accum), 16'h00fe);
  endtask

  task automatic sc_timer();
    prescToTimer = 1'b1;
    run(14'h0081);
    check("prescClear", 16'(prescClear), 16'h0001);
    run(14'h0a01);
    check("prescClear", 16'(prescClear), 16'h0000);
    run(14'h0a81);
    check("prescClear", 16'(prescClear), 16'h0001);
    prescToTimer = 1'b0;
    run(14'h0081);
    check("prescClear", 16'(prescClear), 16'h0000);
  endtask

  task automatic sc_power();
    run(14'h0060);
    expect_wr(1'b0, 7'h00, 8'h00);
    check("accum", 16'(accum), 16'h00ff);
    run(14'h0063);
    check("standbyReq", 16'(standbyReq), 16'h0001);
    check("status", 16'(status[4:3]), 16'h0002);
    run(14'h0064);
    check("watchdogClear", 16'(watchdogClear), 16'h0001);
    check("status", 16'(status[4:3]), 16'h0003);
  endtask

  // ----------------------------------------------------------------------
  // clock, sequence and hang guard
  // ----------------------------------------------------------------------
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    sc_arith();
    sc_logic();
    sc_rotate();
    sc_skip();
    sc_bits();
    sc_ctrl();
    sc_port();
    sc_timer();
    sc_power();
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end
endmodule
